// ==== csf_pkg.sv ====
// constants and carrier types for the cpu status flag block
package csf_pkg;

	// ****************************************
	// register byte addresses
	// ****************************************
	localparam logic [7:0] ADDR_FLAGS   = 8'h00;
	localparam logic [7:0] ADDR_PCL     = 8'h04;
	localparam logic [7:0] ADDR_TPL     = 8'h08;
	localparam logic [7:0] ADDR_TPH     = 8'h0C;
	localparam logic [7:0] ADDR_TRH     = 8'h10;
	localparam logic [7:0] ADDR_IRQ_ST  = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MSK = 8'h18;
	localparam logic [7:0] ADDR_PC_ALL  = 8'h1C;

	// ****************************************
	// flag register bit positions
	// ****************************************
	localparam int unsigned F_C   = 0;
	localparam int unsigned F_AC  = 1;
	localparam int unsigned F_Z   = 2;
	localparam int unsigned F_OV  = 3;
	localparam int unsigned F_PDF = 4;
	localparam int unsigned F_TO  = 5;
	localparam int unsigned F_CZ  = 6;
	localparam int unsigned F_SC  = 7;
	localparam logic [7:0] FLAG_WR_MASK = 8'hCF;
	localparam logic [7:0] FLAG_RST     = 8'h00;

	// ****************************************
	// interrupt status bits
	// ****************************************
	localparam int unsigned IRQ_N      = 4;
	localparam int unsigned IRQ_WDT    = 0;
	localparam int unsigned IRQ_HALT   = 1;
	localparam int unsigned IRQ_TBL    = 2;
	localparam int unsigned IRQ_BRANCH = 3;

	// ****************************************
	// bus answers and datapath widths
	// ****************************************
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned NIB_W  = 4;

	// ****************************************
	// alu operations
	// ****************************************
	typedef enum logic [8:0] {
		OP_ADD = 9'h001,
		OP_ADC = 9'h002,
		OP_SUB = 9'h004,
		OP_SBC = 9'h008,
		OP_RLC = 9'h010,
		OP_RRC = 9'h020,
		OP_AND = 9'h040,
		OP_OR  = 9'h080,
		OP_XOR = 9'h100
	} csf_op_e;

	// operation request from the instruction datapath
	typedef struct packed {
		logic       valid;
		csf_op_e    op;
		logic [7:0] a;
		logic [7:0] b;
	} csf_alu_req_s;

	// byte with a valid strobe
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} csf_byte_s;

	// system events from watchdog and sleep logic
	typedef struct packed {
		logic wdt_timeout;
		logic watchdog_clear_instruction;
		logic halt;
	} csf_sys_ev_s;

endpackage

// ==== csf_status_properties.sv ====
// port-level assertions for the status flag block
`timescale 1ns/1ps
module csf_status_properties #(
	parameter int unsigned PC_W = 13,
	parameter int unsigned PW_W = 16
) (
	input wire logic                  i_clk,
	input wire logic                  i_reset,
	input wire csf_pkg::csf_alu_req_s i_alu_req,
	input wire csf_pkg::csf_sys_ev_s  i_sys_ev,
	input wire logic                  i_pc_step,
	input wire logic                  i_tbl_valid,
	input wire logic [PW_W-1:0]       i_tbl_word,
	input wire logic                  o_s_bvalid,
	input wire csf_pkg::csf_byte_s    o_alu_result,
	input wire csf_pkg::csf_byte_s    o_tbl_low,
	input wire logic [PC_W-1:0]       o_pc,
	input wire logic                  o_dummy_cycle,
	input wire logic [7:0]            o_flags
);
	import csf_pkg::*;
	// ****
	// checks
	// ****
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// low byte of a fetched word leaves one edge later
	sequence s_tbl_out;
		o_tbl_low.valid && o_tbl_low.data == $past(i_tbl_word[7:0]);
	endsequence
	a_sys_keep: assert property (
		i_sys_ev == 3'h0 |=> $stable(o_flags[5:4])) else $error("sys moved");
	a_to_set: assert property (
		i_sys_ev.wdt_timeout |=> o_flags[5]) else $error("to not set");
	a_halt_ev: assert property (i_sys_ev.halt |=> o_flags[4] &&
		o_flags[5] == $past(i_sys_ev.wdt_timeout)) else $error("halt bad");
	a_watchdog_clear_instruction: assert property (
		i_sys_ev == 3'h2 |=> o_flags[5:4] == 2'h0) else $error("clr bad");
	a_sc_xor: assert property (
		i_alu_req.valid && |(i_alu_req.op & 9'h00F) |=> o_alu_result.valid
		&& o_flags[7] == (o_flags[3] ^ o_alu_result.data[7]))
		else $error("sc bad");
	a_cz_sub: assert property (
		i_alu_req.valid && i_alu_req.op == OP_SUB |=> o_flags[6] == o_flags[2])
		else $error("cz sub bad");
	a_cz_keep: assert property (
		i_alu_req.valid && |(i_alu_req.op & 9'h1F3) |=> $stable(o_flags[6]))
		else $error("cz moved");
	a_dummy_src: assert property (
		o_dummy_cycle |-> o_s_bvalid ##1 !o_dummy_cycle)
		else $error("dummy bad");
	a_pc_frozen: assert property (
		o_dummy_cycle && i_pc_step |=> $stable(o_pc)) else $error("pc moved");
	a_tbl_low: assert property (i_tbl_valid |=> s_tbl_out)
		else $error("tbl low bad");
endmodule

// ==== csf_status_regs.sv ====
// status flags, program counter low byte and table pointer registers
//
// What this block does
// - software write to pc low byte jumps within current page
// - each pc low byte write inserts one dummy instruction cycle
// - two table pointers form table address, writable like plain registers
// - table read puts high byte in result register, low byte out
// - flag register writes never touch watchdog expiry or sleep flags
// - watchdog expiry set by time-out, cleared by power-up, clear, halt
// - sleep flag set by halt, cleared by power-up or watchdog clear
// - carry is add carry-out or subtract no-borrow; rotates update it
// - half carry is nibble carry or nibble no-borrow
// - zero flag set when an arithmetic or logic result is zero; rotates leave it
// - signed range flag is carry into msb xor carry out
// - sign xor flag equals signed range flag xor result msb
// - plain subtract copies zero flag into chained zero flag
// - subtract with borrow ands chained zero with new zero flag
// - other operations leave chained zero flag unchanged
// - calls and interrupts never save the flag register automatically
// - watchdog and sleep flags reset to zero; others unspecified
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module csf_status_regs #(
	parameter int unsigned PC_W   = 13,
	parameter int unsigned PW_W   = 16,
	parameter int unsigned ADDR_W = 8
) (
	input  wire logic                i_clk,
	input  wire logic                i_reset,
	input  wire logic [ADDR_W-1:0]   i_s_awaddr,
	input  wire logic                i_s_awvalid,
	output logic                     o_s_awready,
	input  wire logic [31:0]         i_s_wdata,
	input  wire logic [3:0]          i_s_wstrb,
	input  wire logic                i_s_wvalid,
	output logic                     o_s_wready,
	output logic [1:0]               o_s_bresp,
	output logic                     o_s_bvalid,
	input  wire logic                i_s_bready,
	input  wire logic [ADDR_W-1:0]   i_s_araddr,
	input  wire logic                i_s_arvalid,
	output logic                     o_s_arready,
	output logic [31:0]              o_s_rdata,
	output logic [1:0]               o_s_rresp,
	output logic                     o_s_rvalid,
	input  wire logic                i_s_rready,
	input  wire csf_pkg::csf_alu_req_s i_alu_req,
	output csf_pkg::csf_byte_s       o_alu_result,
	input  wire csf_pkg::csf_sys_ev_s i_sys_ev,
	input  wire logic                i_pc_step,
	output logic [PC_W-1:0]          o_pc,
	output logic                     o_dummy_cycle,
	input  wire logic                i_tbl_valid,
	input  wire logic [PW_W-1:0]     i_tbl_word,
	output logic [2*8-1:0]           o_tbl_addr,
	output csf_pkg::csf_byte_s       o_tbl_low,
	output logic [7:0]               o_flags,
	output logic                     o_irq
);
	import csf_pkg::*;

	// ****************************************
	// behaviour notes for the next engineer
	// ****************************************
	// reset
	//   reset is asynchronous and clears the whole state record; the
	//   readies rise on the first edge after release, and requests
	//   should start no earlier than that edge
	// register bus
	//   write address and write data are taken in either order; the
	//   register write happens one edge after both halves are held,
	//   and the response rises on that same edge
	//   each ready stays low from its own handshake until the response
	//   has been taken, so one write is in flight at a time
	//   a read answers on the same edge that takes its address; the read
	//   mux has no side effects, so a repeated read is harmless
	//   unmapped addresses answer with an error response, no effect
	//   a clear write strobe bit zero leaves every register untouched
	// flag register
	//   software writes reach only the arithmetic and composite bits;
	//   the watchdog and sleep bits follow system events alone
	//   an alu operation in the same cycle as a bus write wins
	//   set events are applied after clear events, so a time-out in
	//   the same cycle as a clear or halt leaves the expiry bit set
	//   arithmetic bits are forced to zero at reset; their value after
	//   power-up is free, and zero keeps simulation free of unknowns
	// alu
	//   subtraction is a plus inverted b plus carry-in, so the carry
	//   and half carry read as no-borrow
	//   the signed range bit compares the carry into bit seven with
	//   the carry out of it, using a seven bit partial sum
	//   rotates touch only carry; logic operations touch only zero
	//   an unknown operation code passes a through and leaves flags
	// program counter
	//   a low byte write replaces the low eight bits and keeps the
	//   page bits; the step input is ignored in the write cycle and
	//   in the dummy cycle that follows, which stands for one clock
	//   the full counter is readable at its own address for debug
	// table read
	//   the two pointer bytes drive the table address continuously;
	//   software steps them by read-modify-write over the bus
	//   a fetched word lands high byte in the result register and
	//   the low byte leaves on a one-cycle strobe toward data memory
	// interrupts
	//   status bits are sticky and cleared by writing ones; a new
	//   event in the same cycle as its clear keeps the bit set
	//   the request output is the registered or of the status bits anded with the mask
	// hazards
	//   every output is a flip-flop, so each answer trails its cause
	//   by one edge; callers must not expect same-cycle results
	//   flags are never stacked on calls or interrupts; firmware
	//   saves them itself where it needs them

	// ****************************************
	// state of the whole block
	// ****************************************
	typedef struct packed {
		logic              aw_got;
		logic              w_got;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
		logic [7:0]        flags;
		logic [PC_W-1:0]   pc;
		logic              dummy;
		logic [7:0]        tpl;
		logic [7:0]        tph;
		logic [7:0]        trh;
		csf_byte_s         tbl_low;
		csf_byte_s         alu;
		logic [IRQ_N-1:0]  irq_st;
		logic [IRQ_N-1:0]  irq_msk;
		logic              irq;
	} csf_state_s;

	csf_state_s st_q;
	csf_state_s st_d;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic             do_wr;
		logic             wr_en;
		logic [7:0]       wb;
		logic [IRQ_N-1:0] ev;
		logic [7:0]       bb;
		logic             cin;
		logic [8:0]       sum;
		logic [4:0]       lo;
		logic [7:0]       lo7;
		logic [7:0]       res;
		logic             ov;
		logic             zr;
		logic             hit;
		logic [31:0]      rd;
		do_wr = 1'b0;
		wr_en = 1'b0;
		wb    = 8'h00;
		ev    = '0;
		bb    = 8'h00;
		cin   = 1'b0;
		sum   = 9'h000;
		lo    = 5'h00;
		lo7   = 8'h00;
		res   = 8'h00;
		ov    = 1'b0;
		zr    = 1'b0;
		hit   = 1'b0;
		rd    = 32'h0000_0000;
		st_d  = st_q;
		st_d.alu.valid     = 1'b0;
		st_d.tbl_low.valid = 1'b0;
		st_d.dummy         = 1'b0;

		// write address and data captured in either order
		if (i_s_awvalid && st_q.awready) begin
			st_d.awaddr = i_s_awaddr;
			st_d.aw_got = 1'b1;
		end
		if (i_s_wvalid && st_q.wready) begin
			st_d.wdata = i_s_wdata;
			st_d.wstrb = i_s_wstrb;
			st_d.w_got = 1'b1;
		end

		// register write once both halves are held
		do_wr = st_q.aw_got && st_q.w_got && !st_q.bvalid;
		wr_en = do_wr && st_q.wstrb[0];
		wb    = st_q.wdata[7:0];
		if (do_wr) begin
			st_d.bvalid = 1'b1;
			unique case (st_q.awaddr[7:0])
				ADDR_FLAGS, ADDR_PCL, ADDR_TPL, ADDR_TPH,
				ADDR_TRH, ADDR_IRQ_ST, ADDR_IRQ_MSK,
				ADDR_PC_ALL: st_d.bresp = RESP_OKAY;
				default:     st_d.bresp = RESP_SLVERR;
			endcase
		end
		if (wr_en) begin
			unique case (st_q.awaddr[7:0])
				ADDR_FLAGS: begin
					st_d.flags = (st_q.flags & ~FLAG_WR_MASK)
						| (wb & FLAG_WR_MASK);
				end
				ADDR_PCL: begin
					st_d.pc[7:0] = wb;
					st_d.dummy   = 1'b1;
					ev[IRQ_BRANCH] = 1'b1;
				end
				ADDR_TPL:     st_d.tpl = wb;
				ADDR_TPH:     st_d.tph = wb;
				ADDR_IRQ_ST:  st_d.irq_st = st_q.irq_st & ~wb[IRQ_N-1:0];
				ADDR_IRQ_MSK: st_d.irq_msk = wb[IRQ_N-1:0];
				default:      st_d.flags = st_q.flags;
			endcase
		end
		if (st_q.bvalid && i_s_bready) begin
			st_d.bvalid = 1'b0;
			st_d.aw_got = 1'b0;
			st_d.w_got  = 1'b0;
		end
		st_d.awready = !st_d.aw_got && !st_d.bvalid;
		st_d.wready  = !st_d.w_got && !st_d.bvalid;

		// read mux, no read side effects
		hit = 1'b1;
		unique case (i_s_araddr[7:0])
			ADDR_FLAGS:   rd[7:0] = st_q.flags;
			ADDR_PCL:     rd[7:0] = st_q.pc[7:0];
			ADDR_TPL:     rd[7:0] = st_q.tpl;
			ADDR_TPH:     rd[7:0] = st_q.tph;
			ADDR_TRH:     rd[7:0] = st_q.trh;
			ADDR_IRQ_ST:  rd[IRQ_N-1:0] = st_q.irq_st;
			ADDR_IRQ_MSK: rd[IRQ_N-1:0] = st_q.irq_msk;
			ADDR_PC_ALL:  rd[PC_W-1:0] = st_q.pc;
			default:      hit = 1'b0;
		endcase
		if (i_s_arvalid && st_q.arready) begin
			st_d.rvalid = 1'b1;
			st_d.rdata  = rd;
			st_d.rresp  = hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (st_q.rvalid && i_s_rready) begin
			st_d.rvalid = 1'b0;
		end
		st_d.arready = !st_d.rvalid;

		// program counter stepping, held during the dummy cycle
		if (i_pc_step && !st_q.dummy && !st_d.dummy) begin
			st_d.pc = st_q.pc + PC_W'(1);
		end

		// table read result capture
		if (i_tbl_valid) begin
			st_d.trh = i_tbl_word[PW_W-1 -: BYTE_W];
			st_d.tbl_low.valid = 1'b1;
			st_d.tbl_low.data  = i_tbl_word[BYTE_W-1:0];
			ev[IRQ_TBL] = 1'b1;
		end

		// alu flags override a bus write in the same cycle
		if (i_alu_req.valid) begin
			bb  = i_alu_req.b;
			cin = 1'b0;
			if (i_alu_req.op == OP_ADC) begin
				cin = st_q.flags[F_C];
			end
			if (i_alu_req.op == OP_SUB) begin
				bb  = ~i_alu_req.b;
				cin = 1'b1;
			end
			if (i_alu_req.op == OP_SBC) begin
				bb  = ~i_alu_req.b;
				cin = st_q.flags[F_C];
			end
			sum = {1'b0, i_alu_req.a} + {1'b0, bb} + {8'h00, cin};
			lo  = {1'b0, i_alu_req.a[NIB_W-1:0]}
				+ {1'b0, bb[NIB_W-1:0]} + {4'h0, cin};
			lo7 = {1'b0, i_alu_req.a[6:0]} + {1'b0, bb[6:0]}
				+ {7'h00, cin};
			ov  = lo7[7] ^ sum[8];
			res = sum[7:0];
			unique case (i_alu_req.op)
				OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
					zr = (res == 8'h00);
					st_d.flags[F_C]  = sum[8];
					st_d.flags[F_AC] = lo[NIB_W];
					st_d.flags[F_Z]  = zr;
					st_d.flags[F_OV] = ov;
					st_d.flags[F_SC] = ov ^ res[7];
					if (i_alu_req.op == OP_SUB) begin
						st_d.flags[F_CZ] = zr;
					end
					if (i_alu_req.op == OP_SBC) begin
						st_d.flags[F_CZ] = st_q.flags[F_CZ] & zr;
					end
				end
				OP_RLC: begin
					res = {i_alu_req.a[6:0], st_q.flags[F_C]};
					st_d.flags[F_C] = i_alu_req.a[7];
				end
				OP_RRC: begin
					res = {st_q.flags[F_C], i_alu_req.a[7:1]};
					st_d.flags[F_C] = i_alu_req.a[0];
				end
				OP_AND, OP_OR, OP_XOR: begin
					if (i_alu_req.op == OP_AND) begin
						res = i_alu_req.a & i_alu_req.b;
					end else if (i_alu_req.op == OP_OR) begin
						res = i_alu_req.a | i_alu_req.b;
					end else begin
						res = i_alu_req.a ^ i_alu_req.b;
					end
					st_d.flags[F_Z] = (res == 8'h00);
				end
				default: res = i_alu_req.a;
			endcase
			st_d.alu.valid = 1'b1;
			st_d.alu.data  = res;
		end

		// system flags, set applied last so it wins
		if (i_sys_ev.watchdog_clear_instruction) begin
			st_d.flags[F_TO]  = 1'b0;
			st_d.flags[F_PDF] = 1'b0;
		end
		if (i_sys_ev.halt) begin
			st_d.flags[F_TO]  = 1'b0;
			st_d.flags[F_PDF] = 1'b1;
			ev[IRQ_HALT] = 1'b1;
		end
		if (i_sys_ev.wdt_timeout) begin
			st_d.flags[F_TO] = 1'b1;
			ev[IRQ_WDT] = 1'b1;
		end

		// sticky events, set beats a clear in the same cycle
		st_d.irq_st = st_d.irq_st | ev;
		st_d.irq    = |(st_d.irq_st & st_d.irq_msk);
	end

	// ****************************************
	// state register
	// ****************************************
	// flags and pc reset to zero; no stacking of flags
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// outputs straight from state
	// ****************************************
	assign o_s_awready   = st_q.awready;
	assign o_s_wready    = st_q.wready;
	assign o_s_bvalid    = st_q.bvalid;
	assign o_s_bresp     = st_q.bresp;
	assign o_s_arready   = st_q.arready;
	assign o_s_rvalid    = st_q.rvalid;
	assign o_s_rdata     = st_q.rdata;
	assign o_s_rresp     = st_q.rresp;
	assign o_alu_result  = st_q.alu;
	assign o_pc          = st_q.pc;
	assign o_dummy_cycle = st_q.dummy;
	assign o_tbl_addr    = {st_q.tph, st_q.tpl};
	assign o_tbl_low     = st_q.tbl_low;
	assign o_flags       = st_q.flags;
	assign o_irq         = st_q.irq;

endmodule

// ==== csf_status_regs_bench.sv ====
// self-checking bench for the status flag block
`timescale 1ns/1ps
module csf_status_regs_bench;
	import csf_pkg::*;
	logic         clk = 1'h0, rst = 1'h1, step = 1'h0, tv = 1'h0;
	logic         awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic         arvalid = 1'h0, rready = 1'h0;
	logic [7:0]   awaddr = 8'h00, araddr = 8'h00, fm = 8'h00;
	logic [31:0]  wdata = 32'h0, rv;
	logic [15:0]  tw = 16'h0, taddr;
	csf_alu_req_s req = '0;
	csf_sys_ev_s  ev = '0;
	logic         awready, wready, bvalid, arready, rvalid, irq, dummy;
	logic [1:0]   bresp, rresp, r;
	logic [31:0]  rdata;
	csf_byte_s    res, tlo;
	logic [12:0]  pc;
	logic [7:0]   flags;
	logic [2:0]   evs [7] = '{3'h4, 3'h1, 3'h4, 3'h2, 3'h3, 3'h5, 3'h6};
	int           fail_count = 0, n_checks = 0;
	csf_status_regs csf_status_regs_i (.i_clk(clk), .i_reset(rst),
		.i_s_awaddr(awaddr), .i_s_awvalid(awvalid), .o_s_awready(awready),
		.i_s_wdata(wdata), .i_s_wstrb(4'hF), .i_s_wvalid(wvalid),
		.o_s_wready(wready), .o_s_bresp(bresp), .o_s_bvalid(bvalid),
		.i_s_bready(bready), .i_s_araddr(araddr), .i_s_arvalid(arvalid),
		.o_s_arready(arready), .o_s_rdata(rdata), .o_s_rresp(rresp),
		.o_s_rvalid(rvalid), .i_s_rready(rready), .i_alu_req(req),
		.o_alu_result(res), .i_sys_ev(ev), .i_pc_step(step), .o_pc(pc),
		.o_dummy_cycle(dummy), .i_tbl_valid(tv), .i_tbl_word(tw),
		.o_tbl_addr(taddr), .o_tbl_low(tlo), .o_flags(flags), .o_irq(irq));
	// ****
	// helpers
	// ****
	always #25 clk = ~clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d fails %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// bus write; a low byte pc write raises step at the answer edge
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'h0;
		step <= (a == 8'h04);
		#1;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'h0;
		end while (!rvalid);
		rv = rdata;
		r = rresp;
		rready <= 1'h0;
		#1;
	endtask
	task automatic pulse(input logic [2:0] v);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev <= 3'h0;
		#1;
	endtask
	// one alu operation against the flag model
	task automatic alu(input int k, input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		logic [7:0] y, e;
		logic c, ci;
		int t;
		c = fm[0];
		y = (k == 2 || k == 3) ? ~b : b;
		ci = (k == 0) ? 1'h0 : (k == 2) ? 1'h1 : c;
		e = a;
		if (k < 4) begin
			s = a + y + ci;
			t = a[6:0] + y[6:0] + ci;
			e = s[7:0];
			fm[0] = s[8];
			fm[1] = (a[3:0] + y[3:0] + ci) > 15;
			fm[3] = t[7] ^ s[8];
			fm[7] = fm[3] ^ e[7];
			if (k == 2) fm[6] = (e == 8'h00);
			if (k == 3) fm[6] = fm[6] & (e == 8'h00);
		end else if (k < 6) begin
			e = (k == 4) ? {a[6:0], c} : {c, a[7:1]};
			fm[0] = (k == 4) ? a[7] : a[0];
		end else
			e = (k == 6) ? a & b : (k == 7) ? a | b : a ^ b;
		if (k < 4 || k > 5) fm[2] = (e == 8'h00);
		@(posedge clk);
		req <= {1'h1, csf_op_e'(9'h1 << k), a, b};
		@(posedge clk);
		req.valid <= 1'h0;
		#1;
		chk(res, {1'h1, e});
		chk(flags, fm);
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		void'($urandom(18615));
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		rd(8'h00);
		chk(rv, 32'h0);
		repeat (6) for (int k = 0; k < 9; k++)
			alu(k, 8'($urandom), 8'($urandom));
		alu(2, 8'h55, 8'h55);
		alu(3, 8'h12, 8'h12);
		alu(0, 8'h7F, 8'h01);
		foreach (evs[i]) begin
			pulse(evs[i]);
			fm[5] = evs[i][2] | (fm[5] & ~|evs[i][1:0]);
			fm[4] = evs[i][0] | (fm[4] & ~evs[i][1]);
			chk(flags, fm);
			if (i == 2) begin
				wr(8'h00, 32'h0);
				fm &= 8'h30;
				chk(flags, fm);
			end
		end
		// interrupt raise, mask and clear
		wr(8'h14, 32'hF);
		wr(8'h18, 32'h1);
		pulse(3'h4);
		@(posedge clk);
		#1;
		chk(irq, 1'h1);
		wr(8'h14, 32'h1);
		chk(irq, 1'h0);
		wr(8'h18, 32'h0);
		pulse(3'h4);
		@(posedge clk);
		#1;
		chk(irq, 1'h0);
		rd(8'h14);
		chk(rv[0], 1'h1);
		wr(8'h20, 32'h5);
		chk(r, RESP_SLVERR);
		rd(8'h24);
		chk(r, RESP_SLVERR);
		// page jump with step held through the dummy cycle
		@(posedge clk);
		step <= 1'h1;
		repeat (300) @(posedge clk);
		#1;
		chk(pc, 13'h12C);
		wr(8'h04, 32'hA7);
		repeat (4) @(posedge clk);
		step <= 1'h0;
		#1;
		chk(pc, 13'h1AB);
		// table pointers, increment and table read
		wr(8'h08, 32'h3C);
		wr(8'h0C, 32'h5A);
		rd(8'h08);
		wr(8'h08, rv + 32'h1);
		chk(taddr, 16'h5A3D);
		@(posedge clk);
		tw <= 16'($urandom);
		tv <= 1'h1;
		@(posedge clk);
		tv <= 1'h0;
		#1;
		chk(tlo, {1'h1, tw[7:0]});
		wr(8'h10, 32'h0);
		rd(8'h10);
		chk(rv, {24'h0, tw[15:8]});
		print_verdict;
	end
	// hang guard
	initial begin
		#500000;
		fail_count++;
		print_verdict;
	end
endmodule
bind csf_status_regs csf_status_properties #(.PC_W(PC_W), .PW_W(PW_W))
	csf_status_properties_i (.i_clk(i_clk), .i_reset(i_reset),
	.i_alu_req(i_alu_req), .i_sys_ev(i_sys_ev), .i_pc_step(i_pc_step),
	.i_tbl_valid(i_tbl_valid), .i_tbl_word(i_tbl_word),
	.o_s_bvalid(o_s_bvalid), .o_alu_result(o_alu_result),
	.o_tbl_low(o_tbl_low), .o_pc(o_pc), .o_dummy_cycle(o_dummy_cycle),
	.o_flags(o_flags));
